// *** common/nbsr_pkg.sv ***
/*
 * Shared constants for the nine bit shift register block.
 * Assumes a single system clock at 100 MHz and an active high async reset.
 */
// Function
// - One nine bit register, bits 0 to 8, parallel input and output each.
// - Select picks shift or load; driver sets it before the edge.
// - Shifting moves data from bit 0 toward bit 8 only.
// - Loads and shifts happen on a rising edge of either clock.
// - Master clear high zeroes all bits at once and blocks clock edges.
// - Load mode: each bit takes the parallel input of same index.
// - Shift mode: bit 0 takes serial input, others take the bit below.
// - Bit 7 drives a complementary pair, parallel and serial output.
// - Bits 0 to 6 and 8 drive single ended outputs of stored value.
// - Open inputs default low, giving load mode with clear inactive.
// - Serial input and clocks are complementary pairs; device uses difference.
package nbsr_pkg;
    localparam int          NBSR_WIDTH      = 9;
    localparam int          NBSR_PAIR_BIT   = 7;
    localparam logic [8:0]  NBSR_RESET_VAL  = 9'h000;
    localparam int          NBSR_FIFO_DEPTH = 16;
    localparam int          NBSR_FIFO_AW    = 4;
    localparam logic        NBSR_SEL_LOAD   = 1'b0;
    localparam logic        NBSR_SEL_SHIFT  = 1'b1;
    localparam logic [6:0]  NBSR_CTL_IDLE   = 7'h2a;
endpackage

// *** src/nbsr_fifo.sv ***
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an active high asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module nbsr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign o_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_valid = (count_reg != '0);
    assign o_data  = mem[rptr_reg];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wptr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** src/nbsr_top.sv ***
/*
 * Nine bit shift register with parallel load and serial shift.
 * Assumes all pin inputs are asynchronous to I_CLK_SYS; clock pins are
 * sampled and their rising edges become one-cycle update enables.
 */
`timescale 1ns/100ps
`default_nettype none
module nbsr_top
    import nbsr_pkg::*;
(
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RST,
    input  wire logic [8:0] I_DATA,
    input  wire logic       I_SERIAL_P,
    input  wire logic       I_SERIAL_N,
    input  wire logic       I_CLOCK_A_P,
    input  wire logic       I_CLOCK_A_N,
    input  wire logic       I_CLOCK_B_P,
    input  wire logic       I_CLOCK_B_N,
    input  wire logic       I_SEL,
    input  wire logic       I_MASTER_CLEAR,
    output logic [8:0]      O_BIT_OUT,
    output logic            O_BIT_OUT_7_PAIR_P,
    output logic            O_BIT_OUT_7_PAIR_N,
    output logic [8:0]      O_STREAM_DATA,
    output logic            O_STREAM_VALID,
    input  wire logic       I_STREAM_READY,
    output logic            O_STREAM_OVERRUN
);
    // Two stage synchronisers; stage one is read only by stage two.
    logic [8:0] data_s1_reg;
    logic [8:0] data_s2_reg;
    logic [6:0] ctl_s1_reg;
    logic [6:0] ctl_s2_reg;
    logic       clk_comb_d_reg;
    logic       serial_in;
    logic       clk_comb;
    logic       clk_rise;
    logic       clear_s;
    logic       sel_s;
    logic [8:0] shreg_reg;
    logic [8:0] shreg_next;
    logic       upd_reg;
    logic       fifo_in_ready;
    logic [8:0] fifo_q;
    logic       fifo_q_valid;
    logic       fifo_out_ready;

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            data_s1_reg <= NBSR_RESET_VAL;
            data_s2_reg <= NBSR_RESET_VAL;
            ctl_s1_reg  <= NBSR_CTL_IDLE;
            ctl_s2_reg  <= NBSR_CTL_IDLE;
        end else begin
            data_s1_reg <= I_DATA;
            data_s2_reg <= data_s1_reg;
            ctl_s1_reg  <= {I_SERIAL_P, I_SERIAL_N, I_CLOCK_A_P,
                            I_CLOCK_A_N, I_CLOCK_B_P, I_CLOCK_B_N,
                            I_SEL};
            ctl_s2_reg  <= ctl_s1_reg;
        end
    end

    // Clear also gets a two stage synchroniser; the register takes it asynchronously too.
    logic clr_s1_reg;
    logic clr_s2_reg;
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            clr_s1_reg <= 1'b0;
            clr_s2_reg <= 1'b0;
        end else begin
            clr_s1_reg <= I_MASTER_CLEAR;
            clr_s2_reg <= clr_s1_reg;
        end
    end
    assign clear_s = clr_s2_reg;

    // A pair reads high only when the true side is above the inverted one.
    assign serial_in = ctl_s2_reg[6] & ~ctl_s2_reg[5];
    assign clk_comb  = (ctl_s2_reg[4] & ~ctl_s2_reg[3])
                     | (ctl_s2_reg[2] & ~ctl_s2_reg[1]);
    assign sel_s     = ctl_s2_reg[0];
    assign clk_rise  = clk_comb && !clk_comb_d_reg;

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            clk_comb_d_reg <= 1'b0;
        end else begin
            clk_comb_d_reg <= clk_comb;
        end
    end

    always_comb begin
        shreg_next = shreg_reg;
        if (sel_s == NBSR_SEL_SHIFT) begin
            shreg_next = {shreg_reg[7:0], serial_in};
        end else begin
            shreg_next = data_s2_reg;
        end
    end

    // The register itself; the clear also acts as the async reset path.
    always_ff @(posedge I_CLK_SYS or posedge I_RST or
                posedge I_MASTER_CLEAR) begin
        if (I_RST || I_MASTER_CLEAR) begin
            shreg_reg <= NBSR_RESET_VAL;
        end else if (clear_s) begin
            shreg_reg <= NBSR_RESET_VAL;
        end else if (clk_rise) begin
            shreg_reg <= shreg_next;
        end
    end

    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_BIT_OUT          <= NBSR_RESET_VAL;
            O_BIT_OUT_7_PAIR_P <= 1'b0;
            O_BIT_OUT_7_PAIR_N <= 1'b1;
        end else begin
            O_BIT_OUT          <= shreg_reg;
            O_BIT_OUT_7_PAIR_P <= shreg_reg[NBSR_PAIR_BIT];
            O_BIT_OUT_7_PAIR_N <= ~shreg_reg[NBSR_PAIR_BIT];
        end
    end

    // Each update pushes the new word into the stream FIFO; one that finds it full is dropped and sets the overrun flag.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            upd_reg          <= 1'b0;
            O_STREAM_OVERRUN <= 1'b0;
        end else begin
            upd_reg <= clk_rise && !clear_s && !I_MASTER_CLEAR;
            if (upd_reg && !fifo_in_ready) begin
                O_STREAM_OVERRUN <= 1'b1;
            end
        end
    end

    nbsr_fifo #(
        .WIDTH (NBSR_WIDTH),
        .DEPTH (NBSR_FIFO_DEPTH),
        .AW    (NBSR_FIFO_AW)
    ) u_fifo (
        .i_clk   (I_CLK_SYS),
        .i_rst   (I_RST),
        .i_data  (shreg_reg),
        .i_valid (upd_reg),
        .o_ready (fifo_in_ready),
        .o_data  (fifo_q),
        .o_valid (fifo_q_valid),
        .i_ready (fifo_out_ready)
    );

    // The stage refills whenever it is empty or being drained, so a stalled
    // consumer leaves one word here and sixteen in the FIFO before overrun.
    assign fifo_out_ready = !O_STREAM_VALID || I_STREAM_READY;

    // Output stage register keeps stream outputs straight from flops.
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_STREAM_VALID <= 1'b0;
            O_STREAM_DATA  <= NBSR_RESET_VAL;
        end else if (fifo_out_ready) begin
            O_STREAM_VALID <= fifo_q_valid;
            O_STREAM_DATA  <= fifo_q;
        end
    end

    property p_load;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        clk_rise && !clear_s && sel_s == NBSR_SEL_LOAD
        |=> shreg_reg == $past(data_s2_reg);
    endproperty
    a_load: assert property (p_load) else $error("load wrong");

    property p_shift;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        clk_rise && !clear_s && sel_s == NBSR_SEL_SHIFT
        |=> shreg_reg == {$past(shreg_reg[7:0]), $past(serial_in)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong");

    property p_hold;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        !clk_rise && !clear_s |=> $stable(shreg_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("update w/o edge");

    property p_clear;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        clear_s |-> shreg_reg == NBSR_RESET_VAL;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_pair;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        O_BIT_OUT_7_PAIR_P != O_BIT_OUT_7_PAIR_N
        && O_BIT_OUT_7_PAIR_P == O_BIT_OUT[NBSR_PAIR_BIT];
    endproperty
    a_pair: assert property (p_pair) else $error("pair mismatch");

    property p_outs;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        ##1 O_BIT_OUT == $past(shreg_reg);
    endproperty
    a_outs: assert property (p_outs) else $error("outputs lag");

    property p_dir;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        clk_rise && !clear_s && sel_s
        |=> shreg_reg[8] == $past(shreg_reg[7]);
    endproperty
    a_dir: assert property (p_dir) else $error("wrong direction");

    property p_comb;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        $rose(ctl_s2_reg[4] & ~ctl_s2_reg[3]) && !clk_comb_d_reg
        |-> clk_rise;
    endproperty
    a_comb: assert property (p_comb) else $error("clock a missed");

    // Named steps of one update: the edge is taken, then shown two cycles on.
    sequence s_take_load;
        clk_rise && !clear_s && sel_s == NBSR_SEL_LOAD;
    endsequence

    sequence s_take_shift;
        clk_rise && !clear_s && sel_s == NBSR_SEL_SHIFT;
    endsequence

    sequence s_taken;
        clk_rise && !clear_s;
    endsequence

    property p_load_out;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        s_take_load |-> ##2 O_BIT_OUT == $past(data_s2_reg, 2);
    endproperty
    a_load_out: assert property (p_load_out)
        else $error("loaded word not shown");

    property p_shift_out;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        s_take_shift |-> ##2 O_BIT_OUT ==
            {$past(shreg_reg[7:0], 2), $past(serial_in, 2)};
    endproperty
    a_shift_out: assert property (p_shift_out)
        else $error("shifted word not shown");

    property p_serial_out;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        s_take_shift |-> ##2 O_BIT_OUT_7_PAIR_P == $past(shreg_reg[6], 2);
    endproperty
    a_serial_out: assert property (p_serial_out)
        else $error("serial output wrong");

    property p_push;
        @(posedge I_CLK_SYS) disable iff (I_RST || I_MASTER_CLEAR)
        s_taken |=> upd_reg;
    endproperty
    a_push: assert property (p_push)
        else $error("update not pushed");

    property p_one_pulse;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        clk_rise |=> !clk_rise;
    endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("edge pulse too long");

    property p_clear_out;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        clear_s |=> O_BIT_OUT == NBSR_RESET_VAL && O_BIT_OUT_7_PAIR_N;
    endproperty
    a_clear_out: assert property (p_clear_out)
        else $error("outputs not cleared");

    property p_clear_no_push;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        clear_s |=> !upd_reg;
    endproperty
    a_clear_no_push: assert property (p_clear_no_push)
        else $error("push during clear");

    property p_comb_b;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        $rose(ctl_s2_reg[2] & ~ctl_s2_reg[1]) && !clk_comb_d_reg
        |-> clk_rise;
    endproperty
    a_comb_b: assert property (p_comb_b)
        else $error("clock b missed");

    property p_stream_stand;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        O_STREAM_VALID && !I_STREAM_READY
        |=> O_STREAM_VALID && $stable(O_STREAM_DATA);
    endproperty
    a_stream_stand: assert property (p_stream_stand)
        else $error("stream word dropped");

    property p_overrun_set;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        upd_reg && !fifo_in_ready |=> O_STREAM_OVERRUN;
    endproperty
    a_overrun_set: assert property (p_overrun_set)
        else $error("overrun not flagged");

    property p_overrun_keep;
        @(posedge I_CLK_SYS) disable iff (I_RST)
        O_STREAM_OVERRUN |=> O_STREAM_OVERRUN;
    endproperty
    a_overrun_keep: assert property (p_overrun_keep)
        else $error("overrun flag lost");
endmodule
`default_nettype wire

// *** verification/nbsr_far.sv ***
/*
 * Far-side model: drives the serial pair and both clock pairs.
 * Assumes one request at a time on i_go, sampled on rising edges.
 */
`timescale 1ns/100ps
`default_nettype none
module nbsr_far (
    input  wire logic i_clk,
    input  wire logic i_go,
    input  wire logic i_use_b,
    input  wire logic i_ser,
    output logic      o_ser_p,
    output logic      o_ser_n,
    output logic      o_clk_a_p,
    output logic      o_clk_a_n,
    output logic      o_clk_b_p,
    output logic      o_clk_b_n
);
    logic [2:0] cnt_reg = 3'h0;
    logic       use_b_reg = 1'b0;
    logic       hi;
    always @(posedge i_clk) begin
        if (i_go && cnt_reg == 3'h0) begin
            cnt_reg <= 3'h6;
            use_b_reg <= i_use_b;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
    // Three cycles high, then three low, so the pin sync never misses.
    assign hi = cnt_reg > 3'h3;
    assign o_clk_a_p = hi && !use_b_reg;
    assign o_clk_a_n = ~o_clk_a_p;
    assign o_clk_b_p = hi && use_b_reg;
    assign o_clk_b_n = ~o_clk_b_p;
    assign o_ser_p = i_ser;
    assign o_ser_n = ~i_ser;
endmodule
`default_nettype wire

// *** verification/tb_nbsr_top.sv ***
/*
 * Self-checking bench for the nine bit shift register top.
 * Assumes the far-side model makes the pin clocks and serial pair.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_nbsr_top import nbsr_pkg::*;;
    logic       clk = 0, rst = 1, sel = 0, clr = 0, go = 0;
    logic       use_b = 0, ser = 0, rdy = 0, p7p, p7n, sval, ovr;
    logic [8:0] data = 0, bits, sdata, exp_r = 0, mon_e;
    logic [1:0] rdy_mode = 0;
    wire        sp, sn, ap, an, bp, bn;
    logic [8:0] exp_q[$];
    int         err_count = 0, n_tests = 0, seed;
    nbsr_top i_nbsr_top (.I_CLK_SYS(clk), .I_RST(rst), .I_DATA(data),
        .I_SERIAL_P(sp), .I_SERIAL_N(sn), .I_CLOCK_A_P(ap),
        .I_CLOCK_A_N(an), .I_CLOCK_B_P(bp), .I_CLOCK_B_N(bn),
        .I_SEL(sel), .I_MASTER_CLEAR(clr), .O_BIT_OUT(bits),
        .O_BIT_OUT_7_PAIR_P(p7p), .O_BIT_OUT_7_PAIR_N(p7n),
        .O_STREAM_DATA(sdata), .O_STREAM_VALID(sval),
        .I_STREAM_READY(rdy), .O_STREAM_OVERRUN(ovr));
    nbsr_far i_nbsr_far (.i_clk(clk), .i_go(go), .i_use_b(use_b),
        .i_ser(ser), .o_ser_p(sp), .o_ser_n(sn), .o_clk_a_p(ap),
        .o_clk_a_n(an), .o_clk_b_p(bp), .o_clk_b_n(bn));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        rdy <= rdy_mode[1] ? rdy_mode[0] : 1'($urandom);
    end
    always @(posedge clk) begin
        if (!rst && sval && rdy) begin
            `CHK(exp_q.size() > 0, 1'b1)
            if (exp_q.size() > 0) begin
                mon_e = exp_q.pop_front();
                `CHK(sdata, mon_e)
            end
        end
    end
    task automatic end_sim;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One update: inputs settle three cycles, then one pin clock pulse.
    task automatic upd(input logic s, input logic [8:0] d,
                       input logic si, input logic b);
        @(posedge clk);
        sel <= s;
        data <= d;
        ser <= si;
        use_b <= b;
        repeat (3) @(posedge clk);
        go <= 1'b1;
        // Noted before the pin edge, since the word can leave within 7 cycles.
        // The output stage holds one word besides the FIFO's sixteen.
        if (!clr) begin
            exp_r = s ? {exp_r[7:0], si} : d;
            if (exp_q.size() <= NBSR_FIFO_DEPTH) exp_q.push_back(exp_r);
        end
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(bits, exp_r)
        `CHK({p7p, p7n}, {exp_r[7], ~exp_r[7]})
    endtask
    task automatic wait_q;
        for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk);
        `CHK(exp_q.size() == 0, 1'b1)
    endtask
    initial begin
        seed = $urandom(32'h1ec8);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        upd(0, 9'h000, 0, 0);
        for (int i = 0; i < 4; i++) upd(0, 9'($urandom), 0, i[0]);
        $display("test load done");
        for (int i = 0; i < 10; i++) begin
            upd(1, 9'($urandom), 1'($urandom), i[0]);
        end
        $display("test shift done");
        @(posedge clk);
        clr <= 1'b1;
        exp_r = 9'h000;
        upd(0, 9'h1ff, 1, 1);
        @(posedge clk);
        clr <= 1'b0;
        upd(1, 9'h000, 1, 0);
        $display("test clear done");
        wait_q();
        `CHK(ovr, 1'b0)
        rdy_mode <= 2'b10;
        for (int i = 0; i < NBSR_FIFO_DEPTH + 2; i++) upd(0, 9'($urandom), 0, 0);
        `CHK(ovr, 1'b1)
        rdy_mode <= 2'b11;
        wait_q();
        repeat (4) @(posedge clk);
        `CHK(sval, 1'b0)
        $display("test buffer done");
        end_sim();
    end
    // About 500 cycles are needed; the margin covers a stuck stream.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
